// *** rtl/gpd_nth_select.sv ***
/*
  gpd_nth_select: finds the position of the n-th set bit of a vector and counts the set bits.
  assumes a purely combinational use; n counts from zero.
*/
`timescale 1ns/1ps
module gpd_nth_select #(
  parameter int N = 32,
  parameter int W = 6
) (
  // request
  input wire logic [N-1:0] vec,
  input wire logic [W-1:0] nth,
  // answer
  output logic found,
  output logic [W-1:0] index,
  output logic [W-1:0] total
);
  logic [N:0][W-1:0] pre;
  logic [N-1:0] hit;

  assign pre[0] = '0;
  for (genvar i = 0; i < N; i++) begin : g_bit
    assign pre[i+1] = pre[i] + W'(vec[i]);
    assign hit[i] = vec[i] && (pre[i] == nth);
  end

  assign found = |hit;
  assign total = pre[N];

  always_comb begin
    index = '0;
    for (int i = 0; i < N; i++) begin
      if (hit[i]) begin
        index = W'(i);
      end
    end
  end
endmodule : gpd_nth_select

// *** rtl/gpd_param_diag.sv ***
/*
  gpd_param_diag: gateway parameter decoder and diagnosis telegram builder with an apb register file.
  assumes the station firmware writes the master's parameter bytes over apb, the commissioning tool
  and module bus give synchronous inputs, and software fetches the telegram byte by byte.
*/
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module gpd_param_diag
  import gpd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // register bus
  input wire gpd_pkg::gpd_apb_req_s apb_req,
  output gpd_pkg::gpd_apb_rsp_s apb_rsp,
  // commissioning tool
  input wire logic tool_force_req,
  input wire logic tool_force_exit,
  // module bus state
  input wire logic seq_error,
  input wire gpd_pkg::gpd_diag_head_s diag_head,
  input wire logic [gpd_pkg::NCH-1:0] chan_active,
  input wire logic [gpd_pkg::NCH-1:0][23:0] chan_diag,
  input wire logic [gpd_pkg::NMOD-1:0] mod_capable,
  input wire logic [gpd_pkg::NMOD-1:0][7:0] mod_diag,
  // station outputs
  output logic manual_output_override,
  output logic pd_exchange,
  output logic irq
);
  import gpd_pkg::*;

  logic rst_n;
  logic ovr_inhibit_r;
  logic diag_long_r;
  logic startup_deact_r;
  logic static_cfg_r;
  logic paramd_r;
  logic override_r;
  logic exchange_r;
  logic irq_r;
  logic [7:0] diag_idx_r;
  logic [7:0] diag_len_r;
  logic [NIRQ-1:0] irq_status_r;
  logic [NIRQ-1:0] irq_enable_r;
  logic [NIRQ-1:0] irq_status_nxt;
  logic seq_error_q_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  gpd_reset_sync u_reset_sync (
    .clock(clock),
    .resetn(resetn),
    .rst_sync_n(rst_n)
  );

  // apb decode: one wait state, write takes effect at the edge that sees pready high
  wire access = apb_req.psel && apb_req.penable;
  wire done = access && pready_r;
  wire wr_done = done && apb_req.pwrite;
  wire sel_std = (apb_req.paddr == OFS_PARAM_STD);
  wire sel_dpv1 = (apb_req.paddr == OFS_PARAM_DPV1);
  wire sel_idx = (apb_req.paddr == OFS_DIAG_IDX);
  wire sel_byte = (apb_req.paddr == OFS_DIAG_BYTE);
  wire sel_len = (apb_req.paddr == OFS_DIAG_LEN);
  wire sel_state = (apb_req.paddr == OFS_STATE);
  wire sel_stat = (apb_req.paddr == OFS_IRQ_STATUS);
  wire sel_clr = (apb_req.paddr == OFS_IRQ_CLEAR);
  wire sel_en = (apb_req.paddr == OFS_IRQ_ENABLE);
  wire mapped = sel_std | sel_dpv1 | sel_idx | sel_byte | sel_len | sel_state | sel_stat | sel_clr | sel_en;
  // read-only and write-only words refuse the wrong direction with pslverr
  wire wr_to_ro = apb_req.pwrite && (sel_byte | sel_len | sel_state | sel_stat);
  wire rd_of_wo = !apb_req.pwrite && sel_clr;
  wire dir_bad = wr_to_ro || rd_of_wo;
  wire bad = !mapped || dir_bad;
  // answer launched once per access; pready falling back keeps a held request from being taken twice
  wire answer = access && !pready_r;
  wire wr_std = wr_done && sel_std;
  wire wr_dpv1 = wr_done && sel_dpv1;
  wire wr_param = wr_std || wr_dpv1;
  wire wr_idx = wr_done && sel_idx;
  wire wr_clr = wr_done && sel_clr;
  wire wr_en = wr_done && sel_en;

  // only the documented bits are kept; reserved positions never reach the logic
  wire std_inhibit_nxt = apb_req.pwdata[POS_OVR_INHIBIT];
  wire std_long_nxt = apb_req.pwdata[POS_DIAG_LONG];
  wire dpv1_startup_nxt = apb_req.pwdata[POS_STARTUP_DEACT];
  wire dpv1_static_nxt = apb_req.pwdata[POS_STATIC_CFG];

  // manual output override from the commissioning tool
  // an inhibit set later does not cancel an active override; only an exit ends it
  wire force_blocked = ovr_inhibit_r && paramd_r;
  wire force_accept = tool_force_req && !force_blocked;
  wire force_refused = tool_force_req && force_blocked;
  wire override_nxt = force_accept ? 1'b1 : (tool_force_exit ? 1'b0 : override_r);

  // process data exchange on a module sequence error
  // the two combinations left open stop the exchange, the safer side
  wire keep_on_seq_act = !startup_deact_r && !static_cfg_r;
  wire keep_on_seq_deact = startup_deact_r && static_cfg_r;
  wire exchange_nxt = !seq_error || keep_on_seq_act || keep_on_seq_deact;
  wire seq_rise = seq_error && !seq_error_q_r;

  // diagnosis telegram: entry selection
  logic chan_found;
  logic [CW-1:0] chan_index;
  logic [CW-1:0] chan_total;
  logic mod_found;
  logic [CW-1:0] mod_index;
  logic [CW-1:0] mod_total;
  logic [7:0] diag_byte;

  wire [7:0] chan_rel = diag_idx_r - CHAN_BASE;
  wire [7:0] chan_k = chan_rel / CHAN_BYTES;
  wire [7:0] chan_b = chan_rel - 8'(chan_k * CHAN_BYTES);
  wire [7:0] mod_rel = diag_idx_r - DEV_BYTES;
  // channel list is cut at fifteen entries; further active channels are dropped
  wire [CW-1:0] chan_listed = (chan_total > CHAN_MAX) ? CHAN_MAX : chan_total;
  wire [7:0] len_long = CHAN_BASE + 8'(CHAN_BYTES * 8'(chan_listed));
  wire [7:0] len_short = DEV_BYTES + 8'(mod_total);
  wire [7:0] diag_len_nxt = diag_long_r ? len_long : len_short;

  gpd_nth_select #(
    .N(NCH),
    .W(CW)
  ) u_chan_select (
    .vec(chan_active),
    .nth(chan_k[CW-1:0]),
    .found(chan_found),
    .index(chan_index),
    .total(chan_total)
  );

  gpd_nth_select #(
    .N(NMOD),
    .W(CW)
  ) u_mod_select (
    .vec(mod_capable),
    .nth(mod_rel[CW-1:0]),
    .found(mod_found),
    .index(mod_index),
    .total(mod_total)
  );

  // each section forms its byte on its own; the index then picks one
  wire in_telegram = diag_idx_r < diag_len_nxt;
  wire in_dev = diag_idx_r < DEV_BYTES;
  wire in_ident = diag_idx_r < CHAN_BASE;
  wire chan_in_list = chan_found && (chan_k < 8'(CHAN_MAX));
  wire [7:0] dev_byte = diag_head.dev[8*diag_idx_r[0] +: 8];
  wire [7:0] mod_byte = mod_found ? mod_diag[mod_index[3:0]] : 8'h00;
  wire [7:0] ident_byte = diag_head.ident[8*mod_rel[2:0] +: 8];
  wire [7:0] chan_byte = chan_in_list ? chan_diag[chan_index[4:0]][8*(2 - chan_b[1:0]) +: 8] : 8'h00;

  // byte at the current index, zero past the end of the telegram
  always_comb begin
    diag_byte = 8'h00;
    if (in_telegram) begin
      if (in_dev) begin
        // both formats open with the gateway's own diagnosis
        diag_byte = dev_byte;
      end else if (!diag_long_r) begin
        // shortened format: capable modules follow in slot order
        diag_byte = mod_byte;
      end else if (in_ident) begin
        // identifier field, 64 bits, lowest byte first
        diag_byte = ident_byte;
      end else begin
        // three bytes per active channel, highest byte first
        diag_byte = chan_byte;
      end
    end
  end

  // interrupt events: set wins over a clear in the same cycle
  logic [NIRQ-1:0] irq_event;
  assign irq_event[EV_PARAM] = wr_param;
  assign irq_event[EV_REFUSED] = force_refused;
  assign irq_event[EV_SEQERR] = seq_rise;
  assign irq_event[EV_DIAG] = (diag_len_nxt != diag_len_r);
  wire [NIRQ-1:0] irq_clear = wr_clr ? apb_req.pwdata[NIRQ-1:0] : IRQ_RESET;
  assign irq_status_nxt = (irq_status_r & ~irq_clear) | irq_event;
  wire irq_nxt = |(irq_status_nxt & irq_enable_r);

  // read data mux
  logic [31:0] rd_word;
  always_comb begin
    rd_word = WORD_ZERO;
    if (sel_std) begin
      rd_word[POS_OVR_INHIBIT] = ovr_inhibit_r;
      rd_word[POS_DIAG_LONG] = diag_long_r;
    end else if (sel_dpv1) begin
      rd_word[POS_STARTUP_DEACT] = startup_deact_r;
      rd_word[POS_STATIC_CFG] = static_cfg_r;
    end else if (sel_idx) begin
      rd_word[7:0] = diag_idx_r;
    end else if (sel_byte) begin
      rd_word[7:0] = diag_byte;
    end else if (sel_len) begin
      rd_word[7:0] = diag_len_r;
    end else if (sel_state) begin
      rd_word[POS_ST_OVERRIDE] = override_r;
      rd_word[POS_ST_PARAMD] = paramd_r;
      rd_word[POS_ST_EXCHANGE] = exchange_r;
      rd_word[POS_ST_SEQERR] = seq_error_q_r;
    end else if (sel_stat) begin
      rd_word[NIRQ-1:0] = irq_status_r;
    end else if (sel_en) begin
      rd_word[NIRQ-1:0] = irq_enable_r;
    end
  end

  // apb answer; each field stands one cycle, then drops back to zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= answer;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= answer && bad;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= WORD_ZERO;
    end else begin
      prdata_r <= (answer && !apb_req.pwrite) ? rd_word : WORD_ZERO;
    end
  end

  // parameter storage; defaults are all zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ovr_inhibit_r <= 1'b0;
    end else if (wr_std) begin
      ovr_inhibit_r <= std_inhibit_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      diag_long_r <= 1'b0;
    end else if (wr_std) begin
      diag_long_r <= std_long_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      startup_deact_r <= 1'b0;
    end else if (wr_dpv1) begin
      startup_deact_r <= dpv1_startup_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      static_cfg_r <= 1'b0;
    end else if (wr_dpv1) begin
      static_cfg_r <= dpv1_static_nxt;
    end
  end

  // sticky until reset; refusal of the override depends on it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      paramd_r <= 1'b0;
    end else if (wr_param) begin
      paramd_r <= 1'b1;
    end
  end

  // station state and telegram pointer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      override_r <= 1'b0;
    end else begin
      override_r <= override_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      exchange_r <= 1'b1;
    end else begin
      exchange_r <= exchange_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seq_error_q_r <= 1'b0;
    end else begin
      seq_error_q_r <= seq_error;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      diag_len_r <= DEV_BYTES;
    end else begin
      diag_len_r <= diag_len_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      diag_idx_r <= 8'h00;
    end else if (wr_idx) begin
      diag_idx_r <= apb_req.pwdata[7:0];
    end
  end

  // interrupt registers; the level output is a flop so it never glitches
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_r <= IRQ_RESET;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_r <= IRQ_RESET;
    end else if (wr_en) begin
      irq_enable_r <= apb_req.pwdata[NIRQ-1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign apb_rsp = gpd_apb_rsp_s'{prdata: prdata_r, pready: pready_r, pslverr: pslverr_r};
  assign manual_output_override = override_r;
  assign pd_exchange = exchange_r;
  assign irq = irq_r;
endmodule : gpd_param_diag

// *** rtl/gpd_reset_sync.sv ***
/*
  gpd_reset_sync: two-stage release of the asynchronous active-low reset.
  assumes resetn may fall at any time; release is aligned to clock.
*/
`timescale 1ns/1ps
module gpd_reset_sync (
  // clock and raw reset
  input wire logic clock,
  input wire logic resetn,
  // synchronised reset
  output logic rst_sync_n
);
  logic stage_r;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stage_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      stage_r <= 1'b1;
      rst_sync_n <= stage_r;
    end
  end
endmodule : gpd_reset_sync

// *** shared/gpd_pkg.sv ***
/*
  gpd_pkg: constants, register map and carrier types of the gateway parameter and diagnosis decoder.
  assumes one 10 MHz clock and an apb master with 32-bit data on the register side.
*/
package gpd_pkg;
  localparam int NCH = 32;
  localparam int NMOD = 16;
  localparam int CW = 6;
  localparam logic [CW-1:0] CHAN_MAX = 6'h0f;
  localparam logic [7:0] DEV_BYTES = 8'h02;
  localparam logic [7:0] IDENT_BYTES = 8'h08;
  localparam logic [7:0] CHAN_BYTES = 8'h03;
  localparam logic [7:0] CHAN_BASE = 8'h0a;

  // register byte offsets
  localparam logic [7:0] OFS_PARAM_STD = 8'h00;
  localparam logic [7:0] OFS_PARAM_DPV1 = 8'h04;
  localparam logic [7:0] OFS_DIAG_IDX = 8'h08;
  localparam logic [7:0] OFS_DIAG_BYTE = 8'h0c;
  localparam logic [7:0] OFS_DIAG_LEN = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h1c;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;

  // field positions
  localparam int POS_OVR_INHIBIT = 4;
  localparam int POS_DIAG_LONG = 5;
  localparam int POS_STARTUP_DEACT = 8;
  localparam int POS_STATIC_CFG = 30;
  localparam int POS_ST_OVERRIDE = 0;
  localparam int POS_ST_PARAMD = 1;
  localparam int POS_ST_EXCHANGE = 2;
  localparam int POS_ST_SEQERR = 3;

  // interrupt events
  localparam int NIRQ = 4;
  localparam int EV_PARAM = 0;
  localparam int EV_REFUSED = 1;
  localparam int EV_SEQERR = 2;
  localparam int EV_DIAG = 3;

  localparam logic [NIRQ-1:0] IRQ_RESET = 4'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } gpd_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } gpd_apb_rsp_s;

  typedef struct packed {
    logic [15:0] dev;
    logic [63:0] ident;
  } gpd_diag_head_s;
endpackage : gpd_pkg

// *** test/gpd_dp_master.sv ***
/*
  gpd_dp_master: fieldbus master model handing its parameters to the station over apb.
  assumes the bench watchdog ends a wait that never sees pready.
*/
`timescale 1ns/1ps
module gpd_dp_master
  import gpd_pkg::*;
(
  // clock
  input wire logic clock,
  // register bus
  output gpd_pkg::gpd_apb_req_s apb_req,
  input wire gpd_pkg::gpd_apb_rsp_s apb_rsp
);
  initial apb_req = '0;
  // an idle cycle leads each transfer, so no signal is driven twice in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
    @(posedge clock);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    @(posedge clock iff apb_rsp.pready === 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : xfer
  task automatic dpv1(input logic start, input logic stat, output logic e);
    logic [31:0] q;
    xfer(1'b1, OFS_PARAM_DPV1, {1'b0, stat, 21'h0, start, 8'h00}, q, e);
  endtask : dpv1
endmodule : gpd_dp_master

// *** test/gpd_param_diag_properties.sv ***
/*
  gpd_param_diag_properties: port assertions of the parameter and diagnosis decoder.
  assumes parameters reach the block only by apb writes.
*/
`timescale 1ns/1ps
module gpd_param_diag_properties
  import gpd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // register bus
  input wire gpd_pkg::gpd_apb_req_s apb_req,
  input wire gpd_pkg::gpd_apb_rsp_s apb_rsp,
  // tool and module bus
  input wire logic tool_force_req,
  input wire logic tool_force_exit,
  input wire logic seq_error,
  // outputs
  input wire logic manual_output_override,
  input wire logic pd_exchange,
  input wire logic irq
);
  import gpd_pkg::*;

  logic inh_r, par_r, start_r, stat_r, en_r;
  wire logic [7:0] a = apb_req.paddr;
  wire logic wr_w = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
  wire logic keep_w = start_r == stat_r;
  wire logic refuse_w = tool_force_req && inh_r && par_r;
  wire logic bad_w = a > 8'h20 || a[1:0] != 2'h0 || (apb_req.pwrite ? a inside {8'h0c, 8'h10, 8'h14, 8'h18} : a == 8'h1c);
  // shadow of the written parameters, so rules can be judged from the ports alone
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {inh_r, par_r, start_r, stat_r, en_r} <= 5'h00;
    end else if (wr_w && a == 8'h00) begin
      inh_r <= apb_req.pwdata[4];
      par_r <= 1'b1;
    end else if (wr_w && a == 8'h04) begin
      {stat_r, start_r} <= {apb_req.pwdata[30], apb_req.pwdata[8]};
      par_r <= 1'b1;
    end else if (wr_w && a == 8'h20) begin
      en_r <= apb_req.pwdata[1];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence one_wait_s;
    !apb_rsp.pready ##1 apb_rsp.pready;
  endsequence
  ready_one_wait_a: assert property (apb_req.psel && !apb_req.penable |=> one_wait_s) else $error("bad wait");
  ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("pready held");
  err_decode_a: assert property (apb_rsp.pready |-> apb_rsp.pslverr == bad_w) else $error("bad pslverr");
  err_zero_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0) else $error("err data");
  force_accept_a: assert property (tool_force_req && !(inh_r && par_r) |=> manual_output_override)
    else $error("force not taken");
  force_refuse_a: assert property (refuse_w && !manual_output_override |=> !manual_output_override)
    else $error("force not refused");
  force_exit_a: assert property (tool_force_exit && !tool_force_req |=> !manual_output_override) else $error("no exit");
  refuse_irq_a: assert property (refuse_w && en_r |-> ##[1:3] irq) else $error("no irq");
  exch_keep_a: assert property (seq_error |=> pd_exchange == keep_w) else $error("bad exchange");
  exch_idle_a: assert property (!seq_error |=> pd_exchange) else $error("exchange stopped");
endmodule : gpd_param_diag_properties
bind gpd_param_diag gpd_param_diag_properties chk (.clock(clock), .resetn(resetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .tool_force_req(tool_force_req), .tool_force_exit(tool_force_exit), .seq_error(seq_error),
  .manual_output_override(manual_output_override), .pd_exchange(pd_exchange), .irq(irq));

// *** test/test_gateway_param_diag_decoder.sv ***
/*
  test_gateway_param_diag_decoder: self-checking bench of the decoder.
  assumes the package, model and checker are compiled first; fixed seed.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t %h %h", $time, a, b); end end
module test_gateway_param_diag_decoder;
  import gpd_pkg::*;
  logic clock = 1'b0, resetn = 1'b0, f_req = 1'b0, f_exit = 1'b0, seq = 1'b0;
  gpd_apb_req_s req;
  gpd_apb_rsp_s rsp;
  gpd_diag_head_s head = '0;
  logic [NCH-1:0] act = '0;
  logic [NCH-1:0][23:0] cd = '0;
  logic [NMOD-1:0] cap = '0;
  logic [NMOD-1:0][7:0] md = '0;
  logic ovr, pdx, irq, e;
  logic [31:0] q, lf = 32'h7e8efd50;
  logic [7:0] tg[$];
  int n_errors = 0, checks_done = 0, cyc = 0;
  gpd_dp_master mst (.clock(clock), .apb_req(req), .apb_rsp(rsp));
  gpd_param_diag uut (.clock(clock), .resetn(resetn), .apb_req(req), .apb_rsp(rsp), .tool_force_req(f_req),
    .tool_force_exit(f_exit), .seq_error(seq), .diag_head(head), .chan_active(act), .chan_diag(cd),
    .mod_capable(cap), .mod_diag(md), .manual_output_override(ovr), .pd_exchange(pdx), .irq(irq));
  initial forever #50 clock = ~clock;
  // a run needs a few thousand cycles; this ceiling only cuts a hang
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      results();
    end
  end
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction : rnd
  function automatic void build(input logic lng);
    tg = {head.dev[7:0], head.dev[15:8]};
    if (lng) for (int i = 0; i < 8; i++) tg.push_back(head.ident[8*i+:8]);
    for (int i = 0; i < NCH; i++) if (lng && act[i] && tg.size() < 55) tg = {tg, cd[i][23:16], cd[i][15:8], cd[i][7:0]};
    for (int i = 0; i < NMOD; i++) if (!lng && cap[i]) tg.push_back(md[i]);
  endfunction : build
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    mst.xfer(1'b0, a, 32'h0, q, e);
    `CHK(q, x)
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    mst.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic tool(input logic x);
    @(posedge clock);
    if (x) f_exit <= 1'b1;
    else f_req <= 1'b1;
    @(posedge clock);
    {f_exit, f_req} <= 2'h0;
    repeat (2) @(posedge clock);
  endtask : tool
  task automatic tel(input logic lng, input logic all);
    @(posedge clock);
    head <= 80'({rnd(), rnd(), rnd()});
    act <= all ? '1 : rnd();
    cap <= 16'(rnd());
    for (int k = 0; k < NCH; k++) cd[k] <= 24'(rnd());
    for (int k = 0; k < NMOD; k++) md[k] <= 8'(rnd());
    wr(OFS_PARAM_STD, {26'h0, lng, 5'h00});
    build(lng);
    rd(OFS_DIAG_LEN, 32'(tg.size()));
    for (int i = 0; i <= tg.size(); i++) begin
      wr(OFS_DIAG_IDX, 32'(i));
      rd(OFS_DIAG_BYTE, i < tg.size() ? 32'(tg[i]) : 32'h0);
    end
  endtask : tel
  task automatic results();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    rd(OFS_STATE, 32'h4);
    rd(OFS_DIAG_LEN, 32'h2);
    rd(8'h24, 32'h0);
    `CHK(e, 1'b1)
    rd(OFS_IRQ_CLEAR, 32'h0);
    `CHK(e, 1'b1)
    wr(OFS_PARAM_STD, 32'h0);
    tool(1'b0);
    `CHK(ovr, 1'b1)
    tool(1'b1);
    `CHK(ovr, 1'b0)
    wr(OFS_IRQ_ENABLE, 32'h2);
    wr(OFS_PARAM_STD, 32'h10);
    wr(OFS_IRQ_CLEAR, 32'hf);
    tool(1'b0);
    `CHK(ovr, 1'b0)
    `CHK(irq, 1'b1)
    rd(OFS_IRQ_STATUS, 32'h2);
    wr(OFS_IRQ_CLEAR, 32'h2);
    @(posedge clock);
    `CHK(irq, 1'b0)
    wr(OFS_IRQ_ENABLE, 32'h0);
    tool(1'b0);
    `CHK(irq, 1'b0)
    for (int c = 0; c < 4; c++) begin
      mst.dpv1(c[0], c[1], e);
      @(posedge clock);
      seq <= 1'b1;
      repeat (3) @(posedge clock);
      `CHK(pdx, c[0] == c[1])
      seq <= 1'b0;
      repeat (2) @(posedge clock);
    end
    rd(OFS_IRQ_STATUS, 32'h7);
    // reserved positions set on purpose must change nothing
    wr(OFS_PARAM_DPV1, 32'hbfff_feff);
    rd(OFS_PARAM_DPV1, 32'h0);
    @(posedge clock);
    seq <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK(pdx, 1'b1)
    seq <= 1'b0;
    for (int t = 0; t < 6; t++) tel(t[0], t == 5);
    results();
  end
endmodule : test_gateway_param_diag_decoder
